// ==== common/usbeiu_pkg.sv ====
// Purpose: constants and types shared by the usb event interrupt unit
// Assumes: one core clock at 50 MHz, registers reached over a plain byte-wide port
// Notes: addresses are the printed byte addresses of an 8-bit register space

package usbeiu_pkg;

	// ==========================================================
	// register addresses
	localparam logic [15:0] ADDR_USB_IRQ_ENABLE = 16'h1ff3;
	localparam logic [15:0] ADDR_USB_IRQ_ACK = 16'h1ff4;
	localparam logic [15:0] ADDR_USB_IRQ_MASK = 16'h1ff6;
	localparam logic [15:0] ADDR_USB_IRQ_STATUS = 16'h1ff7;
	localparam logic [15:0] ADDR_SR_STATUS = 16'h1ff8;
	localparam logic [15:0] ADDR_SR_ENABLE = 16'h1ff9;
	localparam logic [15:0] ADDR_SR_MASK = 16'h1ffa;

	// ==========================================================
	// field positions of the usb interrupt registers
	localparam int unsigned BIT_FRAME_START = 7;
	localparam int unsigned BIT_FRAME_END_POINT = 6;
	localparam int unsigned BIT_USB_RSVD = 5;
	localparam int unsigned BIT_FUNCTION_EP3 = 4;
	localparam int unsigned BIT_HUB_EP_ZERO = 3;
	localparam int unsigned NUM_EP = 5;
	// field positions of the suspend/resume registers
	localparam int unsigned BIT_BUS_RESET = 3;
	localparam int unsigned BIT_REMOTE_WAKEUP = 2;
	localparam int unsigned BIT_RESUME_SEEN = 1;
	localparam int unsigned BIT_GLOBAL_SUSPEND = 0;
	// implemented bits; everything else reads zero
	localparam logic [7:0] USB_IRQ_BITS = 8'hdf;
	localparam logic [7:0] SR_BITS = 8'h0f;
	localparam logic [7:0] RESET_VALUE = 8'h00;

	// ==========================================================
	// timing
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned EOF2_LEAD_CLOCKS = 10;
	localparam int unsigned BUS_RESET_MIN_NS = 3000000;
	localparam int unsigned BUS_RESET_CYCLES = (BUS_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SE0_CNT_W = 18;
	localparam int unsigned FRAME_CNT_W = 16;
	localparam logic [1:0] RESUME_EXCLUDED_PORT = 2'h1;

	// ==========================================================
	// types
	typedef enum logic [1:0] {EP_CONTROL, EP_OUT, EP_IN} usbeiu_ep_type_e;

	typedef struct packed {
		logic rx_out;
		logic tx_ready;
		logic tx_complete;
		logic rx_setup;
		logic stall_sent;
	} usbeiu_ep_csr_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} usbeiu_bus_s;

endpackage : usbeiu_pkg

// ==== sim/tb_usb_event_interrupt_unit.sv ====
// Purpose: self-checking bench for the usb event interrupt unit
// Assumes: reset held 12 clocks, bus reset count shortened to SE0_LEN clocks
// Notes: end-point triggers are swept over every type; enables and masks are random
`timescale 1ns/1ns

module tb_usb_event_interrupt_unit;
	// ==========================================================
	// signals
	localparam int unsigned SE0_LEN = 20;
	localparam logic [15:0] A_EN = usbeiu_pkg::ADDR_USB_IRQ_ENABLE;
	localparam logic [15:0] A_ACK = usbeiu_pkg::ADDR_USB_IRQ_ACK;
	localparam logic [15:0] A_MK = usbeiu_pkg::ADDR_USB_IRQ_MASK;
	localparam logic [15:0] A_ST = usbeiu_pkg::ADDR_USB_IRQ_STATUS;
	localparam logic [15:0] A_SST = usbeiu_pkg::ADDR_SR_STATUS;
	localparam logic [15:0] A_SEN = usbeiu_pkg::ADDR_SR_ENABLE;
	localparam logic [15:0] A_SMK = usbeiu_pkg::ADDR_SR_MASK;
	localparam logic [15:0] ADRS [0:7] = '{A_EN, A_ACK, A_MK, A_ST, A_SST, A_SEN, A_SMK, 16'h1ff5};
	// csr before and after each trigger: rx_out, ready drop, setup, complete, stall
	localparam logic [4:0] PRE [0:4] = '{5'h00, 5'h0c, 5'h00, 5'h00, 5'h00};
	localparam logic [4:0] POST [0:4] = '{5'h10, 5'h04, 5'h02, 5'h04, 5'h01};
	logic clk;
	logic srst;
	usbeiu_pkg::usbeiu_bus_s bus;
	logic [7:0] rd_data;
	logic run;
	logic sof_valid;
	logic [15:0] frame_clocks_left;
	usbeiu_pkg::usbeiu_ep_csr_s [4:0] ep_csr;
	usbeiu_pkg::usbeiu_ep_type_e [4:0] ep_type;
	logic line_se0, wakeup_req, resume_seen, global_suspend_seen;
	logic [1:0] resume_port;
	logic irq, usb_logic_reset, mcu_reset_req;
	int failures, cmp_count;
	logic [7:0] d, e, en, mk;

	usbeiu_top #(.BUS_RESET_CYCLES(SE0_LEN)) usbeiu_top_inst (.clk(clk), .srst(srst), .bus(bus),
		.rd_data(rd_data), .sof_valid(sof_valid), .frame_clocks_left(frame_clocks_left), .ep_csr(ep_csr),
		.ep_type(ep_type), .line_se0(line_se0), .wakeup_req(wakeup_req), .resume_seen(resume_seen),
		.resume_port(resume_port), .global_suspend_seen(global_suspend_seen), .irq(irq),
		.usb_logic_reset(usb_logic_reset), .mcu_reset_req(mcu_reset_req));
	usbeiu_frame_model usbeiu_frame_model_inst (.clk(clk), .srst(srst), .run(run), .sof_valid(sof_valid),
		.frame_clocks_left(frame_clocks_left));

	// free-running 50 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ==========================================================
	// bus tasks and expectations
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the read edge, so sample just past it
	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge clk);
		bus.rd <= 1'b1;
		bus.addr <= a;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 v = rd_data;
	endtask : rd

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one-clock event pulse: 0 wakeup, 1 resume on port p, 2 global suspend
	task automatic ev(input int k, input logic [1:0] p);
		@(posedge clk);
		{wakeup_req, resume_seen, global_suspend_seen} <= 3'b100 >> k;
		resume_port <= p;
		@(posedge clk);
		{wakeup_req, resume_seen, global_suspend_seen} <= 3'b000;
	endtask : ev

	// hold se0 for n clocks and check both reset requests; the caller releases it
	task automatic se0(input int n, input logic [1:0] exp);
		@(posedge clk);
		line_se0 <= 1'b1;
		repeat (n) @(posedge clk);
		#1 chk({6'h00, usb_logic_reset, mcu_reset_req}, {6'h00, exp});
	endtask : se0

	function automatic logic ep_hit(input int t, input int k);
		case (k)
			0: return t != int'(usbeiu_pkg::EP_IN);
			2: return t == int'(usbeiu_pkg::EP_CONTROL);
			default: return t != int'(usbeiu_pkg::EP_OUT);
		endcase
	endfunction : ep_hit

	task automatic print_verdict;
		if (failures == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict

	// watchdog: the whole sequence needs well under ten thousand clocks
	initial
	begin
		repeat (50000) @(posedge clk);
		failures++;
		print_verdict();
	end

	// ==========================================================
	// main sequence
	initial
	begin
		srst = 1'b1;
		bus = '0;
		run = 1'b0;
		ep_csr = '0;
		ep_type = '0;
		{line_se0, wakeup_req, resume_seen, global_suspend_seen, resume_port} = '0;
		failures = 0;
		cmp_count = 0;
		void'($urandom(32'hfaee));
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		// every register, the acknowledge and a hole read zero after reset
		foreach (ADRS[j])
		begin
			rd(ADRS[j], d);
			chk(d, 8'h00);
		end
		// every end-point, type and trigger, with random enable and mask
		for (int i = 0; i < 5; i++)
			for (int t = 0; t < 3; t++)
				for (int k = 0; k < 5; k++)
				begin
					@(posedge clk);
					ep_type[i] <= usbeiu_pkg::usbeiu_ep_type_e'(t);
					ep_csr[i] <= usbeiu_pkg::usbeiu_ep_csr_s'(PRE[k]);
					wr(A_ACK, 8'hff);
					@(posedge clk);
					ep_csr[i] <= usbeiu_pkg::usbeiu_ep_csr_s'(POST[k]);
					en = 8'($urandom);
					mk = 8'($urandom);
					e = 8'(ep_hit(t, k)) << i;
					wr(A_EN, en);
					wr(A_MK, mk);
					rd(A_ST, d);
					chk(d, e);
					chk({7'h00, irq}, {7'h00, |(e & en & ~mk & 8'hdf)});
					rd(A_EN, d);
					chk(d, en & 8'hdf);
					rd(A_MK, d);
					chk(d, mk & 8'hdf);
					@(posedge clk);
					ep_csr[i] <= '0;
				end
		// status is read-only
		wr(A_ACK, 8'hff);
		wr(A_ST, 8'hff);
		rd(A_ST, d);
		chk(d, 8'h00);
		// frame events: end-of-frame point exactly at 10 clocks left, then start of frame
		wr(A_EN, 8'h40);
		wr(A_MK, 8'h00);
		@(posedge clk);
		run <= 1'b1;
		for (int n = 0; n < 200 && frame_clocks_left !== 16'h000a; n++) @(negedge clk);
		chk({7'h00, irq}, 8'h00);
		@(negedge clk);
		chk({7'h00, irq}, 8'h01);
		for (int n = 0; n < 200 && sof_valid !== 1'b1; n++) @(negedge clk);
		@(posedge clk);
		run <= 1'b0;
		rd(A_ST, d);
		chk(d, 8'hc0);
		wr(A_ACK, 8'h40);
		rd(A_ST, d);
		chk(d, 8'h80);
		chk({7'h00, irq}, 8'h00);
		wr(A_EN, 8'h80);
		rd(A_EN, d);
		chk({7'h00, irq}, 8'h01);
		wr(A_MK, 8'h80);
		rd(A_MK, d);
		chk({7'h00, irq}, 8'h00);
		// corner: an acknowledge landing on the edge of a new start of frame loses to the set
		wr(A_ACK, 8'hff);
		@(posedge clk);
		run <= 1'b1;
		for (int n = 0; n < 200 && frame_clocks_left !== 16'h0000; n++) @(negedge clk);
		wr(A_ACK, 8'hc0);
		run <= 1'b0;
		rd(A_ST, d);
		chk(d, 8'h80);
		// suspend/resume flags, enables and visibility
		wr(A_SEN, 8'hff);
		rd(A_SEN, d);
		chk(d, 8'h0f);
		wr(A_SMK, 8'hf7);
		rd(A_SMK, d);
		chk(d, 8'h07);
		for (int p = 0; p < 4; p++)
		begin
			ev(1, 2'(p));
			rd(A_SST, d);
			chk(d, (p == 1) ? 8'h00 : 8'h02);
			wr(A_SST, 8'h00);
		end
		ev(0, 2'h0);
		rd(A_SST, d);
		chk(d, 8'h04);
		chk({7'h00, irq}, 8'h01);
		ev(1, 2'h3);
		ev(2, 2'h0);
		rd(A_SST, d);
		chk(d, 8'h07);
		wr(A_SST, 8'h0d);
		rd(A_SST, d);
		chk(d, 8'h05);
		wr(A_SMK, 8'h00);
		rd(A_SMK, d);
		chk({7'h00, irq}, 8'h00);
		wr(A_SST, 8'h00);
		// bus reset: too short, without separation, then separated
		se0(SE0_LEN / 2, 2'b00);
		@(posedge clk);
		line_se0 <= 1'b0;
		se0(SE0_LEN + 5, 2'b01);
		rd(A_SST, d);
		chk(d, 8'h00);
		@(posedge clk);
		line_se0 <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk({6'h00, usb_logic_reset, mcu_reset_req}, 8'h00);
		wr(A_SMK, 8'h08);
		se0(SE0_LEN + 5, 2'b10);
		rd(A_SST, d);
		chk(d, 8'h08);
		chk({7'h00, irq}, 8'h01);
		@(posedge clk);
		line_se0 <= 1'b0;
		print_verdict();
	end
endmodule : tb_usb_event_interrupt_unit

// ==== sim/usbeiu_frame_model.sv ====
// Purpose: frame timer and start-of-frame source in place of the usb serial engine
// Assumes: one clk domain, srst synchronous active high
// Notes: frame length is shortened so that a frame lasts a few dozen clocks
`timescale 1ns/1ns

module usbeiu_frame_model #(
	parameter int unsigned FRAME_LEN = 40
)(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// control from the bench
	input wire logic run,
	// frame events toward the block
	output logic sof_valid,
	output logic [15:0] frame_clocks_left
);
	// ==========================================================
	// frame countdown
	localparam logic [15:0] LAST = 16'(FRAME_LEN - 1);

	// counts down to zero, then a one-clock start-of-frame pulse; halts while run is low
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sof_valid <= 1'b0;
			frame_clocks_left <= LAST;
		end
		else if (!run)
			sof_valid <= 1'b0;
		else if (frame_clocks_left == 16'h0000)
		begin
			sof_valid <= 1'b1;
			frame_clocks_left <= LAST;
		end
		else
		begin
			sof_valid <= 1'b0;
			frame_clocks_left <= frame_clocks_left - 16'h0001;
		end
	end
endmodule : usbeiu_frame_model

// ==== verilog/usbeiu_top.sv ====
// Purpose: usb hub/function event flags, enables and masks with one interrupt request
// Assumes: all event inputs come from logic on clk; register port answers reads one cycle later
// Notes: hardware sets always win over a firmware clear in the same cycle
//
// Overview of operation
// - end-point events depend on type: out/control, in/control, setup control only
// - a valid start-of-frame packet sets status bit 7
// - status bit 6 sets exactly 10 clocks before the next frame start
// - bit 5 of status, mask, acknowledge and enable always reads zero
// - status bits: 4 function ep3, 3 hub ep0, 2..0 function ep2..ep0
// - end-point flag sets on out-rx, ready-drop with complete, setup, complete, stall sent
// - a 1 in the usb mask register masks that interrupt
// - writing 1 to an acknowledge bit clears only that flag
// - a 1 in the usb enable register enables that interrupt
// - bus-reset flag sets only when its enable and mask bits are both 1
// - separated bus reset (se0 over 3 ms) resets usb logic, not the cpu
// - wakeup request sets status bit 2, interrupts when enable bit 2 and mask bit 2 are both set
// - resume on any port but port 1 sets status bit 1
// - global suspend signalling sets status bit 0
// - suspend/resume enable bits 2..0 raise interrupts for their flags
// - suspend/resume mask gates the interrupt together with the enable; bits 7..4 read zero
// - firmware clears suspend/resume flags by writing 0 to the flag

`timescale 1ns/1ns

module usbeiu_top #(
	parameter int unsigned BUS_RESET_CYCLES = usbeiu_pkg::BUS_RESET_CYCLES
)(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register port
	input wire usbeiu_pkg::usbeiu_bus_s bus,
	output logic [7:0] rd_data,
	// frame events from the serial engine and hub frame timer
	input wire logic sof_valid,
	input wire logic [usbeiu_pkg::FRAME_CNT_W-1:0] frame_clocks_left,
	// end-point control/status bits, index equals status bit position
	input wire usbeiu_pkg::usbeiu_ep_csr_s [usbeiu_pkg::NUM_EP-1:0] ep_csr,
	input wire usbeiu_pkg::usbeiu_ep_type_e [usbeiu_pkg::NUM_EP-1:0] ep_type,
	// suspend/resume events
	input wire logic line_se0,
	input wire logic wakeup_req,
	input wire logic resume_seen,
	input wire logic [1:0] resume_port,
	input wire logic global_suspend_seen,
	// requests to the rest of the chip
	output logic irq,
	output logic usb_logic_reset,
	output logic mcu_reset_req
);

	// ==========================================================
	// elaboration checks
	if (BUS_RESET_CYCLES < 1 || BUS_RESET_CYCLES >= (1 << usbeiu_pkg::SE0_CNT_W))
	begin : g_bad_reset_cycles
		$error("BUS_RESET_CYCLES out of counter range");
	end

	localparam logic [usbeiu_pkg::SE0_CNT_W-1:0] SE0_LIMIT = usbeiu_pkg::SE0_CNT_W'(BUS_RESET_CYCLES);
	localparam logic [usbeiu_pkg::FRAME_CNT_W-1:0] EOF2_POINT =
		usbeiu_pkg::FRAME_CNT_W'(usbeiu_pkg::EOF2_LEAD_CLOCKS);

	// ==========================================================
	// end-point event decode
	// one function serves all five end-points; edges are taken against the previous csr copy
	function automatic logic ep_event(
		input usbeiu_pkg::usbeiu_ep_type_e kind,
		input usbeiu_pkg::usbeiu_ep_csr_s prev,
		input usbeiu_pkg::usbeiu_ep_csr_s cur
	);
		logic is_ctl;
		logic rx_ok;
		logic tx_ok;
		is_ctl = (kind == usbeiu_pkg::EP_CONTROL);
		rx_ok = is_ctl || (kind == usbeiu_pkg::EP_OUT);
		tx_ok = is_ctl || (kind == usbeiu_pkg::EP_IN);
		ep_event = (rx_ok && cur.rx_out && !prev.rx_out)
			|| (tx_ok && prev.tx_ready && !cur.tx_ready && cur.tx_complete)
			|| (is_ctl && cur.rx_setup && !prev.rx_setup)
			|| (tx_ok && cur.tx_complete && !prev.tx_complete)
			|| (tx_ok && cur.stall_sent && !prev.stall_sent);
	endfunction : ep_event

	// ==========================================================
	// state
	typedef enum {SE0_IDLE, SE0_TIMING, SE0_HELD} usbeiu_se0_state_e;

	logic [7:0] usb_irq_status;
	logic [7:0] usb_irq_enable;
	logic [7:0] usb_irq_mask;
	logic [7:0] suspend_resume_status;
	logic [7:0] suspend_resume_enable;
	logic [7:0] suspend_resume_mask;
	usbeiu_pkg::usbeiu_ep_csr_s [usbeiu_pkg::NUM_EP-1:0] ep_prev;
	logic eof2_seen;
	usbeiu_se0_state_e se0_state;
	logic [usbeiu_pkg::SE0_CNT_W-1:0] se0_count;
	logic separated;

	logic [7:0] next_usb_irq_status;
	logic [7:0] next_usb_irq_enable;
	logic [7:0] next_usb_irq_mask;
	logic [7:0] next_suspend_resume_status;
	logic [7:0] next_suspend_resume_enable;
	logic [7:0] next_suspend_resume_mask;
	logic next_eof2_seen;
	usbeiu_se0_state_e next_se0_state;
	logic [usbeiu_pkg::SE0_CNT_W-1:0] next_se0_count;
	logic next_separated;
	logic [7:0] next_rd_data;
	logic next_irq;
	logic next_usb_logic_reset;
	logic next_mcu_reset_req;

	logic [7:0] usb_set;
	logic [7:0] sr_set;
	logic bus_reset_evt;
	logic frame_end_point_hit;

	// ==========================================================
	// bus reset detection: se0 must outlast the full count before it counts as a reset
	always_comb
	begin
		next_se0_state = se0_state;
		next_se0_count = se0_count;
		next_separated = separated;
		bus_reset_evt = 1'b0;
		case (se0_state)
			SE0_IDLE:
			begin
				next_se0_count = '0;
				if (line_se0)
				begin
					next_se0_state = SE0_TIMING;
					next_se0_count = usbeiu_pkg::SE0_CNT_W'(1);
				end
			end
			SE0_TIMING:
			begin
				if (!line_se0)
					next_se0_state = SE0_IDLE;
				else if (se0_count == SE0_LIMIT)
				begin
					// still low after the limit, so it was held longer than the minimum
					bus_reset_evt = 1'b1;
					next_se0_state = SE0_HELD;
					next_separated = suspend_resume_enable[usbeiu_pkg::BIT_BUS_RESET]
						&& suspend_resume_mask[usbeiu_pkg::BIT_BUS_RESET];
				end
				else
					next_se0_count = se0_count + usbeiu_pkg::SE0_CNT_W'(1);
			end
			SE0_HELD:
			begin
				// reset stays applied until the line leaves se0
				if (!line_se0)
					next_se0_state = SE0_IDLE;
			end
			default:
				next_se0_state = SE0_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			se0_state <= SE0_IDLE;
			se0_count <= '0;
			separated <= 1'b0;
		end
		else
		begin
			se0_state <= next_se0_state;
			se0_count <= next_se0_count;
			separated <= next_separated;
		end
	end

	// ==========================================================
	// hardware event collection
	always_comb
	begin
		usb_set = 8'h00;
		frame_end_point_hit = (frame_clocks_left == EOF2_POINT);
		next_eof2_seen = frame_end_point_hit;
		usb_set[usbeiu_pkg::BIT_FRAME_START] = sof_valid;
		// only the first clock at the point counts, so a stalled timer sets once
		usb_set[usbeiu_pkg::BIT_FRAME_END_POINT] = frame_end_point_hit && !eof2_seen;
		for (int i = 0; i < usbeiu_pkg::NUM_EP; i++)
			usb_set[i] = ep_event(ep_type[i], ep_prev[i], ep_csr[i]);
		sr_set = 8'h00;
		sr_set[usbeiu_pkg::BIT_BUS_RESET] = bus_reset_evt && next_separated;
		sr_set[usbeiu_pkg::BIT_REMOTE_WAKEUP] = wakeup_req;
		sr_set[usbeiu_pkg::BIT_RESUME_SEEN] = resume_seen && (resume_port != usbeiu_pkg::RESUME_EXCLUDED_PORT);
		sr_set[usbeiu_pkg::BIT_GLOBAL_SUSPEND] = global_suspend_seen;
	end

	// ==========================================================
	// register file next values; a set in the clearing cycle survives
	always_comb
	begin
		logic [7:0] ack_clr;
		logic [7:0] sr_clr;
		ack_clr = 8'h00;
		sr_clr = 8'h00;
		next_usb_irq_enable = usb_irq_enable;
		next_usb_irq_mask = usb_irq_mask;
		next_suspend_resume_enable = suspend_resume_enable;
		next_suspend_resume_mask = suspend_resume_mask;
		if (bus.wr)
		begin
			case (bus.addr)
				usbeiu_pkg::ADDR_USB_IRQ_ENABLE: next_usb_irq_enable = bus.wdata & usbeiu_pkg::USB_IRQ_BITS;
				usbeiu_pkg::ADDR_USB_IRQ_MASK: next_usb_irq_mask = bus.wdata & usbeiu_pkg::USB_IRQ_BITS;
				usbeiu_pkg::ADDR_USB_IRQ_ACK: ack_clr = bus.wdata;
				usbeiu_pkg::ADDR_SR_STATUS: sr_clr = ~bus.wdata;
				usbeiu_pkg::ADDR_SR_ENABLE: next_suspend_resume_enable = bus.wdata & usbeiu_pkg::SR_BITS;
				usbeiu_pkg::ADDR_SR_MASK: next_suspend_resume_mask = bus.wdata & usbeiu_pkg::SR_BITS;
				default: ack_clr = 8'h00;
			endcase
		end
		next_usb_irq_status = ((usb_irq_status & ~ack_clr) | usb_set) & usbeiu_pkg::USB_IRQ_BITS;
		next_suspend_resume_status = ((suspend_resume_status & ~sr_clr) | sr_set) & usbeiu_pkg::SR_BITS;
		// interrupt follows the registers it is built from, so it lands with them
		next_irq = |(next_usb_irq_status & next_usb_irq_enable & ~next_usb_irq_mask)
			|| |(next_suspend_resume_status & next_suspend_resume_enable & next_suspend_resume_mask);
		next_usb_logic_reset = (next_se0_state == SE0_HELD) && next_separated;
		next_mcu_reset_req = (next_se0_state == SE0_HELD) && !next_separated;
	end

	// read data; unmapped addresses and the acknowledge register read zero
	always_comb
	begin
		next_rd_data = 8'h00;
		if (bus.rd)
		begin
			case (bus.addr)
				usbeiu_pkg::ADDR_USB_IRQ_ENABLE: next_rd_data = usb_irq_enable;
				usbeiu_pkg::ADDR_USB_IRQ_MASK: next_rd_data = usb_irq_mask;
				usbeiu_pkg::ADDR_USB_IRQ_STATUS: next_rd_data = usb_irq_status;
				usbeiu_pkg::ADDR_SR_STATUS: next_rd_data = suspend_resume_status;
				usbeiu_pkg::ADDR_SR_ENABLE: next_rd_data = suspend_resume_enable;
				usbeiu_pkg::ADDR_SR_MASK: next_rd_data = suspend_resume_mask;
				default: next_rd_data = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			usb_irq_status <= usbeiu_pkg::RESET_VALUE;
			usb_irq_enable <= usbeiu_pkg::RESET_VALUE;
			usb_irq_mask <= usbeiu_pkg::RESET_VALUE;
			suspend_resume_status <= usbeiu_pkg::RESET_VALUE;
			suspend_resume_enable <= usbeiu_pkg::RESET_VALUE;
			suspend_resume_mask <= usbeiu_pkg::RESET_VALUE;
			ep_prev <= '0;
			eof2_seen <= 1'b0;
			rd_data <= 8'h00;
			irq <= 1'b0;
			usb_logic_reset <= 1'b0;
			mcu_reset_req <= 1'b0;
		end
		else
		begin
			usb_irq_status <= next_usb_irq_status;
			usb_irq_enable <= next_usb_irq_enable;
			usb_irq_mask <= next_usb_irq_mask;
			suspend_resume_status <= next_suspend_resume_status;
			suspend_resume_enable <= next_suspend_resume_enable;
			suspend_resume_mask <= next_suspend_resume_mask;
			ep_prev <= ep_csr;
			eof2_seen <= next_eof2_seen;
			rd_data <= next_rd_data;
			irq <= next_irq;
			usb_logic_reset <= next_usb_logic_reset;
			mcu_reset_req <= next_mcu_reset_req;
		end
	end

	// ==========================================================
	// checker helper: consecutive se0 clocks, counted apart from the detector it checks
	logic [usbeiu_pkg::SE0_CNT_W-1:0] se0_run;
	logic [usbeiu_pkg::SE0_CNT_W-1:0] next_se0_run;

	// saturates so a very long se0 cannot wrap back under the limit
	always_comb
	begin
		next_se0_run = se0_run;
		if (!line_se0)
			next_se0_run = '0;
		else if (se0_run != '1)
			next_se0_run = se0_run + usbeiu_pkg::SE0_CNT_W'(1);
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			se0_run <= '0;
		else
			se0_run <= next_se0_run;
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	chk_frame_start_set: assert property (sof_valid |=> usb_irq_status[7])
		else $error("start-of-frame flag not set");

	chk_eof2_point_only: assert property ($rose(usb_irq_status[6]) |-> $past(frame_clocks_left) == EOF2_POINT)
		else $error("frame end point flag rose away from the 10-clock point");

	chk_reserved_zero: assert property (!usb_irq_status[5] && !usb_irq_enable[5] && !usb_irq_mask[5]
		&& suspend_resume_status[7:4] == 4'h0 && suspend_resume_mask[7:4] == 4'h0)
		else $error("reserved bit not zero");

	chk_ack_clears_only: assert property (bus.wr && bus.addr == usbeiu_pkg::ADDR_USB_IRQ_ACK
		|=> ((usb_irq_status & $past(bus.wdata) & ~$past(usb_set)) == 8'h00)
		&& ((usb_irq_status & ~$past(bus.wdata)) == ($past(usb_irq_status) & ~$past(bus.wdata)
		| $past(usb_set) & ~$past(bus.wdata))))
		else $error("acknowledge cleared the wrong flags");

	chk_irq_gating: assert property (##1 irq == (|(usb_irq_status & usb_irq_enable & ~usb_irq_mask)
		|| |(suspend_resume_status & suspend_resume_enable & suspend_resume_mask)))
		else $error("interrupt does not match flags, enables and masks");

	chk_sr_zero_clears: assert property (bus.wr && bus.addr == usbeiu_pkg::ADDR_SR_STATUS
		&& !bus.wdata[0] && !global_suspend_seen |=> !suspend_resume_status[0])
		else $error("writing zero left the suspend flag set");

	chk_separated_reset: assert property (bus_reset_evt && suspend_resume_enable[3] && suspend_resume_mask[3]
		|=> suspend_resume_status[3] && usb_logic_reset && !mcu_reset_req)
		else $error("separated bus reset misbehaved");

	chk_joined_reset: assert property (bus_reset_evt && !(suspend_resume_enable[3] && suspend_resume_mask[3])
		|=> mcu_reset_req && !usb_logic_reset && (suspend_resume_status[3] == $past(suspend_resume_status[3])))
		else $error("bus reset without separation misbehaved");

	chk_se0_length: assert property (bus_reset_evt |-> se0_count == SE0_LIMIT && line_se0)
		else $error("bus reset detected before the se0 limit");

	chk_se0_min_hold: assert property (bus_reset_evt |-> se0_run >= SE0_LIMIT)
		else $error("bus reset detected after too few se0 clocks");

	chk_reset_exclusive: assert property (!(usb_logic_reset && mcu_reset_req))
		else $error("both reset requests active together");

	chk_reset_release: assert property (!line_se0 |=> !usb_logic_reset && !mcu_reset_req)
		else $error("reset request outlived the end of se0");

	chk_resume_port_one: assert property (resume_seen && resume_port == 2'h1 && !suspend_resume_status[1]
		|=> !suspend_resume_status[1])
		else $error("resume on port 1 set the flag");

	chk_wakeup_set: assert property (wakeup_req |=> suspend_resume_status[2])
		else $error("wakeup flag not set");

	chk_setup_control: assert property (ep_type[0] == usbeiu_pkg::EP_CONTROL && ep_csr[0].rx_setup
		&& !ep_prev[0].rx_setup |=> usb_irq_status[0])
		else $error("setup on control end-point lost");

	chk_setup_nonctl: assert property (ep_type[1] == usbeiu_pkg::EP_OUT && $changed(ep_csr[1].rx_setup)
		&& $stable(ep_csr[1].rx_out) && !usb_irq_status[1] && !sof_valid |=> !usb_irq_status[1])
		else $error("setup on out end-point raised a flag");

	cov_frame_irq: cover property (sof_valid ##1 irq ##[1:20] bus.wr && bus.addr == usbeiu_pkg::ADDR_USB_IRQ_ACK);
	cov_separated: cover property (bus_reset_evt && usb_logic_reset == 1'b0 ##1 usb_logic_reset);
	cov_set_beats_clear: cover property (bus.wr && bus.addr == usbeiu_pkg::ADDR_USB_IRQ_ACK
		&& bus.wdata[7] && sof_valid);
	cov_suspend_irq: cover property (global_suspend_seen ##1 irq && suspend_resume_status[0]);
	cov_joined_reset: cover property (bus_reset_evt ##1 mcu_reset_req);

endmodule : usbeiu_top
